// >>> src/css_params.svh
// Offsets, field positions and reset values of the serial slave channel
`ifndef CSS_PARAMS_SVH
`define CSS_PARAMS_SVH

// Register byte addresses
`define CSS_ADDR_DATA 8'h00
`define CSS_ADDR_CTRL 8'h04
`define CSS_ADDR_TRIG 8'h08
`define CSS_ADDR_STAT 8'h0C
`define CSS_ADDR_OLVL 8'h10
`define CSS_ADDR_ISTAT 8'h14
`define CSS_ADDR_IMASK 8'h18

// Control register fields
`define CSS_CTRL_DAP 0
`define CSS_CTRL_CKP 1
`define CSS_CTRL_LSB 2
`define CSS_CTRL_W7 3
`define CSS_CTRL_ISEL 4
`define CSS_CTRL_SOE 5
`define CSS_CTRL_W 6
`define CSS_CTRL_RST 6'h00

// Trigger register fields (read back: bit 0 is the enabled status)
`define CSS_TRIG_START 0
`define CSS_TRIG_STOP 1

// Status register fields
`define CSS_STAT_TSF 0
`define CSS_STAT_BFF 1
`define CSS_STAT_OVF 2
`define CSS_STAT_RXF 3

// Output level register fields
`define CSS_OLVL_SO 0
`define CSS_OLVL_CKO 1
`define CSS_OLVL_CKOE 2
`define CSS_OLVL_RST 3'h3

// Interrupt status and mask fields
`define CSS_IRQ_XFER 0
`define CSS_IRQ_OVR 1
`define CSS_IRQ_W 2

// Fastest serial clock is the operation clock divided by this
`define CSS_MIN_SCK_DIV 6

`endif

// >>> src/css_pkg.sv
// Types shared by the serial slave channel
package css_pkg;
    // Channel shift state, one-hot
    typedef enum logic [1:0] {
        CSS_ST_IDLE = 2'b01,
        CSS_ST_SHIFT = 2'b10
    } css_state_t;
endpackage

// >>> src/css_pin_if.sv
// Synchronised serial pin events passed from the pin stage to the channel
`timescale 1ns/1ps
interface css_pin_if;
    logic lead_edge;
    logic trail_edge;
    logic data_in;

    modport prod (output lead_edge, output trail_edge, output data_in);
    modport cons (input lead_edge, input trail_edge, input data_in);
endinterface

// >>> src/css_pin_sync.sv
// Pin synchroniser and serial clock edge detector
`timescale 1ns/1ps
module css_pin_sync
    import css_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw pins and polarity
    input wire logic sck_pin,
    input wire logic sdi_pin,
    input wire logic polarity,
    // Events to the channel
    css_pin_if.prod ev
);
    logic sck_m_reg;
    logic sck_s_reg;
    logic sdi_m_reg;
    logic sdi_s_reg;
    logic eff_prev_reg;
    logic eff_now;

    // Two-flop synchronisers, first stage read only by the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_m_reg <= 1'b1;
            sck_s_reg <= 1'b1;
            sdi_m_reg <= 1'b0;
            sdi_s_reg <= 1'b0;
        end
        else
        begin
            sck_m_reg <= sck_pin;
            sck_s_reg <= sck_m_reg;
            sdi_m_reg <= sdi_pin;
            sdi_s_reg <= sdi_m_reg;
        end
    end

    // Clock taken straight or inverted, idling high after selection
    assign eff_now = sck_s_reg ^ polarity;

    // Previous effective level for edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            eff_prev_reg <= 1'b1;
        else
            eff_prev_reg <= eff_now;
    end

    // Falling effective edge leads a bit, rising trails it
    assign ev.lead_edge = eff_prev_reg & ~eff_now;
    assign ev.trail_edge = ~eff_prev_reg & eff_now;
    assign ev.data_in = sdi_s_reg;
endmodule // css_pin_sync

// >>> src/css_slave_txrx.sv
// Clocked serial slave channel with simultaneous send and receive, APB registers
// Behaviour
// - Serial clock is never generated; shifting happens only on master edges.
// - External serial clock at most one sixth of the operation clock.
// - Data phase 0: output starts with clock; 1: half clock earlier.
// - Clock polarity bit selects non-inverted or inverted serial clock.
// - Writing stop trigger clears the channel enabled status.
// - Clearing serial output enable stops driving serial data output.
// - When stopped, software sets clock and data output levels directly.
// - A write while buffer full replaces the pending transmit word.
// - Interrupt source may change in operation, before the last bit.
// - Transfer rate comes wholly from master clock, no internal divider.
`timescale 1ns/1ps
`include "css_params.svh"
module css_slave_txrx
    import css_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins
    input wire logic serial_clock_pin,
    output logic serial_clock_level,
    output logic serial_clock_oe,
    input wire logic serial_data_in_pin,
    output logic serial_data_out_pin,
    output logic serial_data_out_oe,
    // Interrupt
    output logic channel_transfer_irq
);
    css_pin_if pin_ev ();

    logic [`CSS_CTRL_W-1:0] ctrl_reg;
    logic [2:0] olvl_reg;
    logic enabled_reg;
    css_state_t state_reg;
    logic [7:0] tx_buf_reg;
    logic buffer_full_reg;
    logic [7:0] tx_sh_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] rx_buf_reg;
    logic rx_full_reg;
    logic overrun_reg;
    logic [2:0] bit_cnt_reg;
    logic out_bit_reg;
    logic [`CSS_IRQ_W-1:0] irq_stat_reg;
    logic [`CSS_IRQ_W-1:0] irq_mask_reg;
    logic [31:0] prdata_reg;

    logic wr_en;
    logic rd_done;
    logic setup;
    logic addr_ok;
    logic dap;
    logic lsb;
    logic w7;
    logic isel;
    logic [2:0] last_bit;
    logic load_now;
    logic sample_now;
    logic word_done;
    logic cur_bit;
    logic [7:0] rx_word;
    logic [`CSS_IRQ_W-1:0] irq_ev;
    logic stop_wr;
    logic start_wr;

    // Orders a word for shifting or delivery by length and bit order
    function automatic logic [7:0] css_order(input logic [7:0] d, input logic lsbf,
                                             input logic len7);
        logic [7:0] m;
        logic [7:0] r;
        m = len7 ? {1'b0, d[6:0]} : d;
        for (int i = 0; i < 8; i++)
            r[i] = m[7-i];
        if (!lsbf)
            css_order = m;
        else
            css_order = len7 ? {1'b0, r[7:1]} : r;
    endfunction

    // Pin synchroniser and edge detector
    css_pin_sync u_pins (
        .pclk(pclk),
        .presetn(presetn),
        .sck_pin(serial_clock_pin),
        .sdi_pin(serial_data_in_pin),
        .polarity(ctrl_reg[`CSS_CTRL_CKP]),
        .ev(pin_ev.prod)
    );

    // Bus decode
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & addr_ok;
    assign rd_done = psel & penable & ~pwrite & addr_ok;
    assign addr_ok = (paddr == `CSS_ADDR_DATA) || (paddr == `CSS_ADDR_CTRL) ||
                     (paddr == `CSS_ADDR_TRIG) || (paddr == `CSS_ADDR_STAT) ||
                     (paddr == `CSS_ADDR_OLVL) || (paddr == `CSS_ADDR_ISTAT) ||
                     (paddr == `CSS_ADDR_IMASK);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = prdata_reg;
    assign stop_wr = wr_en && paddr == `CSS_ADDR_TRIG && pwdata[`CSS_TRIG_STOP];
    assign start_wr = wr_en && paddr == `CSS_ADDR_TRIG && pwdata[`CSS_TRIG_START];

    // Control field aliases
    assign dap = ctrl_reg[`CSS_CTRL_DAP];
    assign lsb = ctrl_reg[`CSS_CTRL_LSB];
    assign w7 = ctrl_reg[`CSS_CTRL_W7];
    assign isel = ctrl_reg[`CSS_CTRL_ISEL];
    assign last_bit = w7 ? 3'h6 : 3'h7;

    // Shift timing, driven only by master edges, sampled at pclk rate
    assign load_now = enabled_reg && buffer_full_reg &&
                      (state_reg == CSS_ST_IDLE || word_done);
    assign sample_now = enabled_reg && state_reg == CSS_ST_SHIFT &&
                        (dap ? pin_ev.lead_edge : pin_ev.trail_edge);
    assign word_done = sample_now && bit_cnt_reg == last_bit;
    assign cur_bit = w7 ? tx_sh_reg[6] : tx_sh_reg[7];
    assign rx_word = css_order({rx_sh_reg[6:0], pin_ev.data_in}, lsb, w7);

    // Event sources: buffer empty when continuous, transfer end when single
    assign irq_ev[`CSS_IRQ_XFER] = isel ? (load_now && enabled_reg)
                                        : word_done;
    assign irq_ev[`CSS_IRQ_OVR] = word_done && rx_full_reg && !rd_data_clear();

    // True when the received word is read in this cycle
    function automatic logic rd_data_clear();
        rd_data_clear = rd_done && paddr == `CSS_ADDR_DATA;
    endfunction

    // Configuration, output levels and mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= `CSS_CTRL_RST;
            olvl_reg <= `CSS_OLVL_RST;
            irq_mask_reg <= '0;
        end
        else if (wr_en)
        begin
            if (paddr == `CSS_ADDR_CTRL)
                ctrl_reg <= pwdata[`CSS_CTRL_W-1:0];
            if (paddr == `CSS_ADDR_OLVL)
                olvl_reg <= pwdata[2:0];
            if (paddr == `CSS_ADDR_IMASK)
                irq_mask_reg <= pwdata[`CSS_IRQ_W-1:0];
        end
    end

    // Channel enable, start and stop triggers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enabled_reg <= 1'b0;
        else if (stop_wr)
            enabled_reg <= 1'b0;
        else if (start_wr)
            enabled_reg <= 1'b1;
    end

    // Transmit buffer; a new write replaces a pending word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_buf_reg <= 8'h00;
            buffer_full_reg <= 1'b0;
        end
        else if (wr_en && paddr == `CSS_ADDR_DATA)
        begin
            tx_buf_reg <= pwdata[7:0];
            buffer_full_reg <= 1'b1;
        end
        else if (load_now || stop_wr)
            buffer_full_reg <= 1'b0;
    end

    // Shift state and bit counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= CSS_ST_IDLE;
            bit_cnt_reg <= 3'h0;
            tx_sh_reg <= 8'h00;
            rx_sh_reg <= 8'h00;
        end
        else if (!enabled_reg || stop_wr)
        begin
            state_reg <= CSS_ST_IDLE;
            bit_cnt_reg <= 3'h0;
        end
        else
        begin
            case (state_reg)
                CSS_ST_IDLE:
                begin
                    if (load_now)
                    begin
                        tx_sh_reg <= css_order(tx_buf_reg, lsb, w7);
                        bit_cnt_reg <= 3'h0;
                        state_reg <= CSS_ST_SHIFT;
                    end
                end
                CSS_ST_SHIFT:
                begin
                    if (load_now)
                    begin
                        tx_sh_reg <= css_order(tx_buf_reg, lsb, w7); // continuous
                        bit_cnt_reg <= 3'h0;
                        rx_sh_reg <= 8'h00;
                    end
                    else if (word_done)
                    begin
                        state_reg <= CSS_ST_IDLE;
                        rx_sh_reg <= 8'h00;
                    end
                    else if (sample_now)
                    begin
                        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                        rx_sh_reg <= {rx_sh_reg[6:0], pin_ev.data_in};
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                end
                default:
                    state_reg <= CSS_ST_IDLE;
            endcase
        end
    end

    // Output bit: phase 1 shows it at load, phase 0 at the leading edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_bit_reg <= 1'b0;
        else if (load_now && dap)
            out_bit_reg <= w7 ? tx_buf_reg[lsb ? 0 : 6] : tx_buf_reg[lsb ? 0 : 7];
        else if (state_reg == CSS_ST_SHIFT && !dap && pin_ev.lead_edge)
            out_bit_reg <= cur_bit;
        else if (state_reg == CSS_ST_SHIFT && dap && pin_ev.trail_edge)
            out_bit_reg <= cur_bit;
    end

    // Receive buffer, full flag and overrun; set wins over read clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_buf_reg <= 8'h00;
            rx_full_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end
        else
        begin
            if (word_done)
                rx_buf_reg <= rx_word;
            rx_full_reg <= word_done | (rx_full_reg & ~rd_data_clear());
            if (irq_ev[`CSS_IRQ_OVR])
                overrun_reg <= 1'b1;
            else if (wr_en && paddr == `CSS_ADDR_STAT && pwdata[`CSS_STAT_OVF])
                overrun_reg <= 1'b0;
        end
    end

    // Sticky interrupt status, cleared by reading it; events win
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_reg <= '0;
        else if (rd_done && paddr == `CSS_ADDR_ISTAT)
            irq_stat_reg <= irq_ev;
        else
            irq_stat_reg <= irq_stat_reg | irq_ev;
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else if (setup && !pwrite)
        begin
            case (paddr)
                `CSS_ADDR_DATA: prdata_reg <= {24'h000000, rx_buf_reg};
                `CSS_ADDR_CTRL: prdata_reg <= {26'h0, ctrl_reg};
                `CSS_ADDR_TRIG: prdata_reg <= {31'h0, enabled_reg};
                `CSS_ADDR_STAT: prdata_reg <= {28'h0, rx_full_reg, overrun_reg,
                                               buffer_full_reg,
                                               state_reg == CSS_ST_SHIFT};
                `CSS_ADDR_OLVL: prdata_reg <= {29'h0, olvl_reg};
                `CSS_ADDR_ISTAT: prdata_reg <= {30'h0, irq_stat_reg};
                `CSS_ADDR_IMASK: prdata_reg <= {30'h0, irq_mask_reg};
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Pin drive: clock only driven from the level register while stopped
    assign serial_clock_level = olvl_reg[`CSS_OLVL_CKO];
    assign serial_clock_oe = ~enabled_reg & olvl_reg[`CSS_OLVL_CKOE];
    assign serial_data_out_pin = enabled_reg ? out_bit_reg : olvl_reg[`CSS_OLVL_SO];
    assign serial_data_out_oe = ctrl_reg[`CSS_CTRL_SOE];

    // Level interrupt from unmasked sticky bits
    assign channel_transfer_irq = |(irq_stat_reg & irq_mask_reg);
endmodule // css_slave_txrx

// >>> verif/css_slave_monitor.sv
// Port checker for the serial slave channel, bound to the top module
`timescale 1ns/1ps
`include "css_params.svh"
module css_slave_monitor
    import css_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Serial pins and interrupt
    input wire logic serial_clock_pin,
    input wire logic serial_clock_level,
    input wire logic serial_clock_oe,
    input wire logic serial_data_out_pin,
    input wire logic serial_data_out_oe,
    input wire logic channel_transfer_irq
);
    logic acc;
    logic unmapped;
    logic en_reg;
    logic sck_reg;
    logic [3:0] quiet_reg;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Access phase and address decode
    assign acc = psel && penable;
    assign unmapped = (paddr[1:0] != 2'h0) || (paddr > `CSS_ADDR_IMASK);

    // Enabled state as software last set it, stop wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            en_reg <= 1'b0;
        else if (acc && pwrite && paddr == `CSS_ADDR_TRIG && pwdata[1:0] != 2'h0)
            en_reg <= !pwdata[`CSS_TRIG_STOP];
    end

    // Cycles since the last serial clock change or bus access, saturating
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_reg <= 1'b1;
            quiet_reg <= 4'h0;
        end
        else
        begin
            sck_reg <= serial_clock_pin;
            if (psel || serial_clock_pin != sck_reg)
                quiet_reg <= 4'h0;
            else if (quiet_reg != 4'hF)
                quiet_reg <= quiet_reg + 4'h1;
        end
    end

    sequence ctrl_wr;
        acc && pwrite && paddr == `CSS_ADDR_CTRL;
    endsequence
    sequence olvl_wr_stopped;
        acc && pwrite && paddr == `CSS_ADDR_OLVL && !en_reg;
    endsequence
    sequence mask_off;
        acc && pwrite && paddr == `CSS_ADDR_IMASK && pwdata[1:0] == 2'h0;
    endsequence

    zero_wait_a: assert property (acc |-> pready)
        else $error("pready low in access phase");
    unmapped_error_a: assert property (acc |-> pslverr == unmapped)
        else $error("pslverr does not match address decode");
    no_clock_drive_a: assert property (en_reg |-> !serial_clock_oe)
        else $error("serial clock driven while enabled");
    output_enable_a: assert property (ctrl_wr |=> serial_data_out_oe == $past(pwdata[5]))
        else $error("data output enable does not follow control write");
    stopped_levels_a: assert property (olvl_wr_stopped |=>
        serial_clock_oe == $past(pwdata[2]) && serial_clock_level == $past(pwdata[1])
        && serial_data_out_pin == $past(pwdata[0]))
        else $error("stopped pin levels do not follow level write");
    data_timing_a: assert property ($changed(serial_data_out_pin) |-> quiet_reg <= 4'h6)
        else $error("data output moved without a clock edge or access");
    irq_timing_a: assert property ($rose(channel_transfer_irq) |-> quiet_reg <= 4'h6)
        else $error("interrupt rose without a cause");
    irq_masked_a: assert property (mask_off |=> !channel_transfer_irq [*2])
        else $error("interrupt high with all sources masked");
endmodule // css_slave_monitor

bind css_slave_txrx css_slave_monitor css_slave_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_pin(serial_clock_pin), .serial_clock_level(serial_clock_level),
    .serial_clock_oe(serial_clock_oe), .serial_data_out_pin(serial_data_out_pin),
    .serial_data_out_oe(serial_data_out_oe), .channel_transfer_irq(channel_transfer_irq));

// >>> verif/css_master_model.sv
// External master model driving the serial clock and data
`timescale 1ns/1ps
module css_master_model
(
    // Clock
    input wire logic pclk,
    // Serial lines
    output logic sck,
    output logic mosi,
    input wire logic miso
);
    localparam int HALF = 8; // Half period in operation clocks, slower than one sixth

    // Idle lines at time zero
    initial
    begin
        sck = 1'b1;
        mosi = 1'b0;
    end

    task automatic half_wait();
        repeat (HALF) @(posedge pclk);
    endtask

    // Park the clock at its idle level for the chosen polarity
    task automatic park(input logic ckp);
        @(posedge pclk);
        sck <= !ckp;
    endtask

    // One word; clock moves only inside the frame
    task automatic xfer(input logic [7:0] tx, input logic [3:0] ctl, output logic [7:0] rx);
        int n;
        int k;
        n = ctl[3] ? 7 : 8;
        rx = 8'h00;
        @(posedge pclk);
        if (ctl[0])
        begin
            mosi <= tx[ctl[2] ? 0 : n - 1];
            half_wait();
        end
        for (int i = 0; i < n; i++)
        begin
            k = ctl[2] ? i : n - 1 - i;
            if (ctl[0])
                rx[k] = miso;
            else
                mosi <= tx[k];
            sck <= ctl[1]; // Leading edge
            half_wait();
            if (!ctl[0])
                rx[k] = miso;
            else if (i < n - 1)
                mosi <= tx[ctl[2] ? i + 1 : n - 2 - i];
            sck <= !ctl[1]; // Trailing edge
            half_wait();
        end
        mosi <= !mosi; // Released line shows the inverse of the last bit
    endtask
endmodule // css_master_model

// >>> verif/clocked_serial_slave_txrx_tb_top.sv
// Self-checking testbench for the serial slave channel
`timescale 1ns/1ps
`include "css_params.svh"
module clocked_serial_slave_txrx_tb_top;
    import css_pkg::*;
    typedef struct {logic [3:0] ctl; logic [7:0] tx; logic [7:0] mtx;} css_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic m_sck, sck_w, mosi, clk_lvl, clk_oe, miso, miso_oe, irq;
    logic [7:0] got;
    int num_errors, samples_checked;
    css_row_t rows [9] = '{'{4'h0, 8'hA5, 8'h3C}, '{4'h1, 8'h81, 8'h7E}, '{4'h2, 8'h5A, 8'hC3},
        '{4'h3, 8'h0F, 8'hF0}, '{4'h4, 8'h96, 8'h69}, '{4'h7, 8'h12, 8'hED},
        '{4'h8, 8'hC1, 8'h2B}, '{4'hD, 8'h55, 8'h3A}, '{4'hE, 8'h6E, 8'h01}};

    // Clock pin resolves between the device drive and the master
    assign sck_w = clk_oe ? clk_lvl : m_sck;

    css_slave_txrx css_slave_txrx_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_clock_pin(sck_w),
        .serial_clock_level(clk_lvl), .serial_clock_oe(clk_oe), .serial_data_in_pin(mosi),
        .serial_data_out_pin(miso), .serial_data_out_oe(miso_oe), .channel_transfer_irq(irq));
    css_master_model css_master_model_inst (.pclk(pclk), .sck(m_sck), .mosi(mosi), .miso(miso));

    // Clock generation
    initial
    begin
        pclk = 1'b0;
    end
    always #50 pclk = !pclk;

    task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk_pin(input string nm, input logic exp, input logic seen);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %b seen %b", nm, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One more edge so that register and pin updates have landed for the caller
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(a, 1'b1, d, q, e);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(a, 1'b0, 32'h0, q, e);
        chk_word(nm, exp, q);
    endtask
    task automatic run(input logic [3:0] ctl, input logic [7:0] mtx);
        css_master_model_inst.xfer(mtx, ctl, got);
        repeat (8) @(posedge pclk);
    endtask

    task automatic final_report();
        if (num_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #3000000;
        num_errors++;
        final_report();
    end

    // Main sequence
    initial
    begin
        logic [31:0] q;
        logic e;
        logic [7:0] m;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        num_errors = 0;
        samples_checked = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[r])
        begin
            m = rows[r].ctl[3] ? 8'h7F : 8'hFF;
            wr(`CSS_ADDR_TRIG, 32'h2);
            css_master_model_inst.park(rows[r].ctl[1]);
            wr(`CSS_ADDR_CTRL, {26'h0, 2'h2, rows[r].ctl});
            wr(`CSS_ADDR_DATA, {24'h0, rows[r].tx});
            wr(`CSS_ADDR_TRIG, 32'h1);
            run(rows[r].ctl, rows[r].mtx);
            chk_word("sent word", {24'h0, rows[r].tx & m}, {24'h0, got});
            rdc("received word", `CSS_ADDR_DATA, {24'h0, rows[r].mtx & m});
            rdc("status idle", `CSS_ADDR_STAT, 32'h0);
        end
        // Mid-run reset, outputs and register reset values, then full setup again
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        chk_pin("irq in reset", 1'b0, irq);
        chk_pin("clock oe in reset", 1'b0, clk_oe);
        chk_pin("clock level in reset", 1'b1, clk_lvl);
        chk_pin("data oe in reset", 1'b0, miso_oe);
        presetn <= 1'b1;
        rdc("ctrl reset", `CSS_ADDR_CTRL, 32'h0);
        rdc("level reset", `CSS_ADDR_OLVL, 32'h3);
        rdc("trig reset", `CSS_ADDR_TRIG, 32'h0);
        rdc("mask reset", `CSS_ADDR_IMASK, 32'h0);
        // Transfer end interrupt raised and cleared, then overrun, masked and unmasked
        css_master_model_inst.park(1'b0);
        wr(`CSS_ADDR_IMASK, 32'h3);
        wr(`CSS_ADDR_CTRL, 32'h20);
        wr(`CSS_ADDR_DATA, 32'h11);
        wr(`CSS_ADDR_TRIG, 32'h1);
        run(4'h0, 8'h22);
        chk_pin("irq after word", 1'b1, irq);
        rdc("event status", `CSS_ADDR_ISTAT, 32'h1);
        chk_pin("irq after clear", 1'b0, irq);
        wr(`CSS_ADDR_DATA, 32'h33);
        run(4'h0, 8'h44);
        rdc("overrun status", `CSS_ADDR_STAT, 32'hC);
        wr(`CSS_ADDR_IMASK, 32'h0);
        chk_pin("irq masked", 1'b0, irq);
        wr(`CSS_ADDR_IMASK, 32'h3);
        chk_pin("irq unmasked", 1'b1, irq);
        rdc("overrun event", `CSS_ADDR_ISTAT, 32'h3);
        wr(`CSS_ADDR_STAT, 32'h4);
        rdc("second word", `CSS_ADDR_DATA, 32'h44);
        rdc("overrun cleared", `CSS_ADDR_STAT, 32'h0);
        // Buffer-empty source, pending word replaced, source switched back in flight
        wr(`CSS_ADDR_TRIG, 32'h2);
        wr(`CSS_ADDR_CTRL, 32'h30);
        wr(`CSS_ADDR_DATA, 32'h5A);
        wr(`CSS_ADDR_DATA, 32'hC3);
        rdc("buffer full", `CSS_ADDR_STAT, 32'h2);
        wr(`CSS_ADDR_TRIG, 32'h1);
        rdc("buffer empty event", `CSS_ADDR_ISTAT, 32'h1);
        wr(`CSS_ADDR_CTRL, 32'h20);
        run(4'h0, 8'h99);
        chk_word("replaced word", 32'hC3, {24'h0, got});
        rdc("end event", `CSS_ADDR_ISTAT, 32'h1);
        // Stop, output enable off, stopped pin levels, unmapped address
        rdc("enabled", `CSS_ADDR_TRIG, 32'h1);
        wr(`CSS_ADDR_TRIG, 32'h2);
        rdc("stopped", `CSS_ADDR_TRIG, 32'h0);
        wr(`CSS_ADDR_CTRL, 32'h0);
        chk_pin("data oe off", 1'b0, miso_oe);
        wr(`CSS_ADDR_OLVL, 32'h4);
        chk_pin("clock driven", 1'b1, clk_oe);
        chk_pin("clock low", 1'b0, clk_lvl);
        chk_pin("data low", 1'b0, miso);
        wr(`CSS_ADDR_OLVL, 32'h3);
        chk_pin("clock released", 1'b0, clk_oe);
        chk_pin("data high", 1'b1, miso);
        apb(8'h1C, 1'b0, 32'h0, q, e);
        chk_pin("unmapped error", 1'b1, e);
        chk_word("unmapped data", 32'h0, q);
        final_report();
    end
endmodule // clocked_serial_slave_txrx_tb_top
